// *** rtl/lcdif_pkg.sv ***
// Shared constants and types for the host port of the character display
// Functional notes
// - Device offers serial, 4-bit and 8-bit parallel.
// - 8-bit mode moves a byte per transfer.
// - 4-bit mode uses upper four data lines.
// - 4-bit byte completes after two nibble transfers.
// - High nibble travels first, low nibble second.
// - Host polls busy only after both nibbles.
// - 4-bit status read returns two nibbles, high first.
// - Serial active when parallel select low, chip select low.
// - Serial bits travel MSB first.
// - Device samples serial input on clock rise.
// - Serial byte delivered on chip select rise.
// - Excess serial bits keep only last eight.
// - Device shifts serial output on clock fall.
// - Host sets select and direction before chip select.
// - Reset selects 8-bit parallel width.
// - Host switches width via function-set instruction.
package lcdif_pkg;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int CLK_PERIOD_NS = 5;
    // Least times, rounded up to whole clock cycles
    localparam int SETUP_NS = 200;
    localparam int HOLD_NS = 200;
    localparam int E_HIGH_NS = 600;
    localparam int SCL_LOW_NS = 700;
    localparam int SCL_HIGH_NS = 300;
    localparam int CS_PULSE_NS = 500;
    localparam logic [7:0] SETUP_CYC =
        8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] HOLD_CYC =
        8'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] E_HIGH_CYC =
        8'((E_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SCL_LOW_CYC =
        8'((SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SCL_HIGH_CYC =
        8'((SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CS_PULSE_CYC =
        8'((CS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic RESET_MODE4 = 1'b0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] PULLUP_BYTE = 8'hFF;

    typedef enum logic [7:0] {
        LCDIF_H_IDLE = 8'h01,
        LCDIF_H_SETUP = 8'h02,
        LCDIF_H_EHIGH = 8'h04,
        LCDIF_H_EHOLD = 8'h08,
        LCDIF_H_SLOW = 8'h10,
        LCDIF_H_SHIGH = 8'h20,
        LCDIF_H_CSEND = 8'h40,
        LCDIF_H_CSGAP = 8'h80
    } lcdif_hstate_t;
endpackage

// *** rtl/lcdif_bus_if.sv ***
// Pin bundle between the microprocessor and the display host port
`timescale 1ns/1ps
interface lcdif_bus_if;
    logic ps;
    logic scl_e;
    logic cs_n;
    logic instr_data_select;
    logic rw;
    logic [7:0] host_dq_o;
    logic host_dq_oe;
    logic [7:0] dev_dq_o;
    logic dev_dq_oe;
    logic si;
    logic so;
    logic so_oe;
    logic [7:0] host_data_line;
    logic so_line;

    // Pull-ups hold undriven lines high
    assign host_data_line = dev_dq_oe ? dev_dq_o :
        (host_dq_oe ? host_dq_o : 8'hFF);
    assign so_line = so_oe ? so : 1'b1;

    modport host (
        output ps, scl_e, cs_n, instr_data_select, rw,
        output host_dq_o, host_dq_oe, si,
        input host_data_line, so_line
    );
    modport device (
        input ps, scl_e, cs_n, instr_data_select, rw,
        input host_data_line, si,
        output dev_dq_o, dev_dq_oe, so, so_oe
    );
endinterface

// *** rtl/lcdif_sync.sv ***
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module lcdif_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// *** rtl/lcdif_device.sv ***
// Display-side end: decodes parallel strobes and the serial shift link
`timescale 1ns/1ps
module lcdif_device (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Pins
    lcdif_bus_if.device bus,
    // Byte to the instruction decoder
    output logic byte_valid_o,
    output logic byte_sel_o,
    output logic [lcdif_pkg::BYTE_W-1:0] byte_data_o,
    // Readback from the decoder
    input wire logic [lcdif_pkg::BYTE_W-1:0] rd_data_i,
    output logic rd_done_o,
    // Width control from the function-set decoder
    input wire logic width_set_i,
    input wire logic width_four_i,
    output logic mode_four_o
);
    import lcdif_pkg::*;

    // Pins cross relative to their idle levels, so the cleared flops read
    // as idle and a reset cannot fake a strobe or chip-select edge
    localparam logic [12:0] PIN_IDLE = {5'h14, PULLUP_BYTE};

    logic [12:0] sync_q;
    logic ps_s, e_s, cs_s, sel_s, rw_s;
    logic [7:0] d_s;
    logic e_d_q, cs_d_q;
    logic e_rise, e_fall, cs_rise, cs_fall, par;
    logic mode4_q, nib_q;
    logic [3:0] hold_q;
    logic valid_q, sel_q, rd_done_q;
    logic [7:0] data_q, dq_q, ser_rd_q;
    logic dq_oe_q;
    logic [7:0] in_sh_q, out_sh_q;
    logic first_q, so_first_q;

    lcdif_sync #(
        .W(13)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i(PIN_IDLE ^ {bus.ps, bus.scl_e, bus.cs_n, bus.instr_data_select,
              bus.rw, bus.host_data_line}),
        .q_o(sync_q)
    );
    assign {ps_s, e_s, cs_s, sel_s, rw_s, d_s} = sync_q ^ PIN_IDLE;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            e_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end else begin
            e_d_q <= e_s;
            cs_d_q <= cs_s;
        end
    end
    // Parallel strobes only count while the select pin is high
    assign par = ps_s;
    assign e_rise = par & e_s & ~e_d_q;
    assign e_fall = par & ~e_s & e_d_q;
    assign cs_rise = ~par & cs_s & ~cs_d_q;
    assign cs_fall = ~par & ~cs_s & cs_d_q;

    // Width register, 8-bit after reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode4_q <= RESET_MODE4;
        end else if (width_set_i) begin
            mode4_q <= width_four_i;
        end
    end
    assign mode_four_o = mode4_q;

    // Which half of a 4-bit pair comes next; shared by reads and writes
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            nib_q <= 1'b0;
        end else if (width_set_i) begin
            nib_q <= 1'b0;
        end else if (e_fall && mode4_q) begin
            nib_q <= ~nib_q;
        end
    end

    // Write path towards the decoder
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            valid_q <= 1'b0;
            sel_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            valid_q <= 1'b0;
            if (e_fall && !rw_s) begin
                if (!mode4_q) begin
                    valid_q <= 1'b1;
                    sel_q <= sel_s;
                    data_q <= d_s;
                end else if (nib_q) begin
                    valid_q <= 1'b1;
                    sel_q <= sel_s;
                    data_q <= {hold_q, d_s[7:4]};
                end
            end else if (cs_rise && !rw_s) begin
                valid_q <= 1'b1;
                sel_q <= sel_s;
                data_q <= in_sh_q;
            end
        end
    end
    assign byte_valid_o = valid_q;
    assign byte_sel_o = sel_q;
    assign byte_data_o = data_q;

    // First nibble of a 4-bit write waits here for its partner
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hold_q <= 4'h0;
        end else if (e_fall && !rw_s && mode4_q && !nib_q) begin
            hold_q <= d_s[7:4];
        end
    end

    // Read path: parallel drive of the data lines
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dq_q <= 8'h00;
            dq_oe_q <= 1'b0;
        end else if (e_rise && rw_s) begin
            dq_oe_q <= 1'b1;
            if (!mode4_q) begin
                dq_q <= rd_data_i;
            end else if (!nib_q) begin
                dq_q <= {rd_data_i[7:4], 4'h0};
            end else begin
                dq_q <= {rd_data_i[3:0], 4'h0};
            end
        end else if (e_fall || !par) begin
            dq_oe_q <= 1'b0;
        end
    end

    // Completion pulse once every nibble of a read is through
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= (e_fall && rw_s && (!mode4_q || nib_q)) ||
                (cs_rise && rw_s);
        end
    end

    // Byte is frozen at frame start for the serial shifter
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ser_rd_q <= 8'h00;
        end else if (cs_fall) begin
            ser_rd_q <= rd_data_i;
        end
    end
    assign rd_done_o = rd_done_q;
    assign bus.dev_dq_o = dq_q;
    assign bus.dev_dq_oe = dq_oe_q;

    // Serial domain, clocked by the link clock
    // Chip select has long setup to the clock, so it is read directly
    always_ff @(posedge bus.scl_e or posedge bus.cs_n) begin
        if (bus.cs_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    always_ff @(posedge bus.scl_e or posedge reset_i) begin
        if (reset_i) begin
            in_sh_q <= 8'h00;
        end else if (!bus.cs_n && !bus.ps) begin
            if (first_q) begin
                in_sh_q <= {7'h00, bus.si};
            end else begin
                in_sh_q <= {in_sh_q[6:0], bus.si};
            end
        end
    end

    // The output side needs its own first-bit flag on the falling edge:
    // the input flag clears at the first rise, which is too early here
    always_ff @(negedge bus.scl_e or posedge bus.cs_n) begin
        if (bus.cs_n) begin
            so_first_q <= 1'b1;
        end else begin
            so_first_q <= 1'b0;
        end
    end

    // Output shifter; first bit stands on the pin before any edge
    always_ff @(negedge bus.scl_e or posedge bus.cs_n or
                posedge reset_i) begin
        if (reset_i || bus.cs_n) begin
            out_sh_q <= 8'h00;
        end else if (so_first_q) begin
            out_sh_q <= {ser_rd_q[6:0], 1'b0};
        end else begin
            out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
    end
    assign bus.so = so_first_q ? ser_rd_q[7] : out_sh_q[7];
    assign bus.so_oe = ~bus.cs_n & ~bus.ps & bus.rw;
endmodule

// *** rtl/lcdif_host.sv ***
// Microprocessor-side end: drives parallel strobes or the serial link
`timescale 1ns/1ps
module lcdif_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Pins
    lcdif_bus_if.host bus,
    // Request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_serial_i,
    input wire logic req_four_i,
    input wire logic req_sel_i,
    input wire logic req_rw_i,
    input wire logic [lcdif_pkg::BYTE_W-1:0] req_data_i,
    // Answer
    output logic rsp_valid_o,
    output logic [lcdif_pkg::BYTE_W-1:0] rsp_data_o
);
    import lcdif_pkg::*;

    lcdif_hstate_t state_q;
    logic [7:0] cnt_q;
    logic [2:0] bit_q;
    logic nib_q, ser_q, four_q, sel_q, rw_q;
    logic [7:0] data_q, sh_q, rd_q, rsp_q;
    logic link_q, cs_n_q, rsp_valid_q;
    logic [8:0] in_s;
    logic so_s;
    logic [7:0] dq_s;
    logic done_cnt;
    logic [7:0] cnt_lim;

    lcdif_sync #(
        .W(9)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i({bus.so_line, bus.host_data_line}),
        .q_o(in_s)
    );
    assign {so_s, dq_s} = in_s;

    always_comb begin
        case (state_q)
            LCDIF_H_SETUP: cnt_lim = SETUP_CYC;
            LCDIF_H_EHIGH: cnt_lim = E_HIGH_CYC;
            LCDIF_H_SLOW: cnt_lim = SCL_LOW_CYC;
            LCDIF_H_SHIGH: cnt_lim = SCL_HIGH_CYC;
            LCDIF_H_CSGAP: cnt_lim = CS_PULSE_CYC;
            default: cnt_lim = HOLD_CYC;
        endcase
    end
    assign done_cnt = (cnt_q == cnt_lim - 8'h01);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= LCDIF_H_IDLE;
            cnt_q <= 8'h00;
            bit_q <= 3'h0;
            nib_q <= 1'b0;
            link_q <= 1'b0;
            cs_n_q <= 1'b1;
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            cnt_q <= done_cnt ? 8'h00 : cnt_q + 8'h01;
            case (state_q)
                LCDIF_H_IDLE: begin
                    cnt_q <= 8'h00;
                    nib_q <= 1'b0;
                    bit_q <= 3'h0;
                    if (req_valid_i) begin
                        state_q <= LCDIF_H_SETUP;
                    end
                end
                LCDIF_H_SETUP: begin
                    if (done_cnt && ser_q) begin
                        cs_n_q <= 1'b0;
                        state_q <= LCDIF_H_SLOW;
                    end else if (done_cnt) begin
                        link_q <= 1'b1;
                        state_q <= LCDIF_H_EHIGH;
                    end
                end
                LCDIF_H_EHIGH: begin
                    if (done_cnt) begin
                        link_q <= 1'b0;
                        state_q <= LCDIF_H_EHOLD;
                    end
                end
                LCDIF_H_EHOLD: begin
                    if (done_cnt && four_q && !nib_q) begin
                        nib_q <= 1'b1;
                        state_q <= LCDIF_H_SETUP;
                    end else if (done_cnt) begin
                        rsp_valid_q <= rw_q;
                        state_q <= LCDIF_H_IDLE;
                    end
                end
                LCDIF_H_SLOW: begin
                    if (done_cnt) begin
                        link_q <= 1'b1;
                        state_q <= LCDIF_H_SHIGH;
                    end
                end
                LCDIF_H_SHIGH: begin
                    if (done_cnt) begin
                        link_q <= 1'b0;
                        bit_q <= bit_q + 3'h1;
                        state_q <= (bit_q == LAST_BIT) ?
                            LCDIF_H_CSEND : LCDIF_H_SLOW;
                    end
                end
                LCDIF_H_CSEND: begin
                    if (done_cnt) begin
                        cs_n_q <= 1'b1;
                        state_q <= LCDIF_H_CSGAP;
                    end
                end
                LCDIF_H_CSGAP: begin
                    if (done_cnt) begin
                        rsp_valid_q <= rw_q;
                        state_q <= LCDIF_H_IDLE;
                    end
                end
                default: begin
                    state_q <= LCDIF_H_IDLE;
                end
            endcase
        end
    end

    // Request latch, serial shifters and read capture
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ser_q <= 1'b0;
            four_q <= 1'b0;
            sel_q <= 1'b0;
            rw_q <= 1'b0;
            data_q <= 8'h00;
            sh_q <= 8'h00;
            rd_q <= 8'h00;
            rsp_q <= 8'h00;
        end else begin
            if (state_q == LCDIF_H_IDLE && req_valid_i) begin
                ser_q <= req_serial_i;
                four_q <= req_four_i;
                sel_q <= req_sel_i;
                rw_q <= req_rw_i;
                data_q <= req_data_i;
                sh_q <= req_data_i;
            end
            if (state_q == LCDIF_H_EHIGH && done_cnt && rw_q) begin
                if (!four_q) begin
                    rd_q <= dq_s;
                end else if (!nib_q) begin
                    rd_q[7:4] <= dq_s[7:4];
                end else begin
                    rd_q[3:0] <= dq_s[7:4];
                end
            end
            if (state_q == LCDIF_H_SHIGH && done_cnt) begin
                sh_q <= {sh_q[6:0], 1'b0};
                rd_q <= {rd_q[6:0], so_s};
            end
            if ((state_q == LCDIF_H_EHOLD || state_q == LCDIF_H_CSGAP) &&
                done_cnt) begin
                rsp_q <= rd_q;
            end
        end
    end

    assign req_ready_o = (state_q == LCDIF_H_IDLE);
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_q;
    assign bus.ps = ~ser_q;
    assign bus.scl_e = link_q;
    assign bus.cs_n = cs_n_q;
    assign bus.instr_data_select = sel_q;
    assign bus.rw = rw_q;
    assign bus.si = sh_q[7];
    // Only the upper lines carry a nibble; the low ones idle at zero
    assign bus.host_dq_o = !four_q ? data_q :
        (nib_q ? {data_q[3:0], 4'h0} : {data_q[7:4], 4'h0});
    assign bus.host_dq_oe = ~ser_q & ~rw_q & (state_q != LCDIF_H_IDLE);
endmodule

// *** testbench/lcdif_bus_properties.sv ***
// Pin-level timing and drive relations between the two ends of the port
`timescale 1ns/1ps
module lcdif_bus_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Pins
    input wire logic ps,
    input wire logic scl_e,
    input wire logic cs_n,
    input wire logic instr_data_select,
    input wire logic rw,
    input wire logic dev_dq_oe,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    property p_so_quiet;
        (cs_n || ps) |-> !so_oe;
    endproperty
    a_so_quiet: assert property (p_so_quiet)
        else $error("serial out driven while deselected");

    property p_so_active;
        (!cs_n && !ps && rw) |-> so_oe;
    endproperty
    a_so_active: assert property (p_so_active)
        else $error("serial read selected but serial out not driven");

    property p_dq_serial;
        !ps |-> !dev_dq_oe;
    endproperty
    a_dq_serial: assert property (p_dq_serial)
        else $error("data lines driven in serial mode");

    // Eight quiet cycles rule out the tail of a read still draining
    property p_dq_write;
        (!rw) [*8] |-> !dev_dq_oe;
    endproperty
    a_dq_write: assert property (p_dq_write)
        else $error("data lines driven during a write");

    property p_dq_release;
        ($fell(scl_e) && ps) |-> ##[1:8] !dev_dq_oe;
    endproperty
    a_dq_release: assert property (p_dq_release)
        else $error("data lines still driven after strobe fall");

    property p_dq_read;
        ($rose(scl_e) && ps && rw) |-> ##[1:8] dev_dq_oe;
    endproperty
    a_dq_read: assert property (p_dq_read)
        else $error("read strobe did not bring data onto the lines");

    property p_so_hold;
        (scl_e && $past(scl_e) && so_oe && $past(so_oe)) |-> $stable(so);
    endproperty
    a_so_hold: assert property (p_so_hold)
        else $error("serial out changed while clock high");

    property p_si_hold;
        (scl_e && $past(scl_e) && !ps) |-> $stable(si);
    endproperty
    a_si_hold: assert property (p_si_hold)
        else $error("serial in changed while clock high");

    property p_sel_settled;
        (!cs_n && !ps) |-> ($stable(rw) && $stable(instr_data_select));
    endproperty
    a_sel_settled: assert property (p_sel_settled)
        else $error("select or direction moved inside a frame");
endmodule

// *** testbench/lcdif_bench.sv ***
// Self-checking bench joining the host end and the display end
`timescale 1ns/1ps
module lcdif_bench;
    import lcdif_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic req_ready_o;
    logic req_serial_i = 1'b0;
    logic req_four_i = 1'b0;
    logic req_sel_i = 1'b0;
    logic req_rw_i = 1'b0;
    logic [7:0] req_data_i = 8'h00;
    logic rsp_valid_o;
    logic [7:0] rsp_data_o;
    logic byte_valid_o;
    logic byte_sel_o;
    logic [7:0] byte_data_o;
    logic [7:0] rd_data_i = 8'h00;
    logic rd_done_o;
    logic width_set_i = 1'b0;
    logic width_four_i = 1'b0;
    logic mode_four_o;
    int mismatches = 0;
    int checked = 0;
    int n_byte = 0;
    int n_rsp = 0;
    int n_done = 0;
    logic [7:0] got_byte = 8'h00;
    logic got_sel = 1'b0;
    logic [7:0] got_rsp = 8'h00;

    always #2.5 clk_i = ~clk_i;

    lcdif_bus_if bus ();
    lcdif_host i_lcdif_host (.clk_i(clk_i), .reset_i(reset_i), .bus(bus),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_serial_i(req_serial_i), .req_four_i(req_four_i),
        .req_sel_i(req_sel_i), .req_rw_i(req_rw_i),
        .req_data_i(req_data_i),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
    lcdif_device i_lcdif_device (.clk_i(clk_i), .reset_i(reset_i),
        .bus(bus), .byte_valid_o(byte_valid_o), .byte_sel_o(byte_sel_o),
        .byte_data_o(byte_data_o), .rd_data_i(rd_data_i),
        .rd_done_o(rd_done_o), .width_set_i(width_set_i),
        .width_four_i(width_four_i), .mode_four_o(mode_four_o));
    lcdif_bus_properties i_lcdif_bus_properties (.clk_i(clk_i),
        .reset_i(reset_i), .ps(bus.ps), .scl_e(bus.scl_e),
        .cs_n(bus.cs_n), .instr_data_select(bus.instr_data_select),
        .rw(bus.rw), .dev_dq_oe(bus.dev_dq_oe), .si(bus.si),
        .so(bus.so), .so_oe(bus.so_oe));

    // Pulses are counted so a stray or missing one shows up
    always @(posedge clk_i) begin
        if (byte_valid_o === 1'b1) begin
            n_byte <= n_byte + 1;
            got_byte <= byte_data_o;
            got_sel <= byte_sel_o;
        end
        if (rsp_valid_o === 1'b1) begin
            n_rsp <= n_rsp + 1;
            got_rsp <= rsp_data_o;
        end
        if (rd_done_o === 1'b1) begin
            n_done <= n_done + 1;
        end
    end

    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_ready();
        int i;
        for (i = 0; i < 5000 && req_ready_o !== 1'b1; i++) begin
            @(negedge clk_i);
        end
        if (req_ready_o !== 1'b1) begin
            mismatches++;
            $display("wrong value req_ready_o expected 1 seen %b",
                     req_ready_o);
            summarize();
        end
    endtask

    task automatic transfer(input logic ser, four, sel, rw,
                            input logic [7:0] data);
        wait_ready();
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_serial_i <= ser;
        req_four_i <= four;
        req_sel_i <= sel;
        req_rw_i <= rw;
        req_data_i <= data;
        @(negedge clk_i);
        wait_ready();
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(negedge clk_i);
        wait_ready();
        // Device reports a few cycles after the closing strobe
        repeat (12) @(negedge clk_i);
    endtask

    task automatic write_op(input logic ser, four, sel,
                            input logic [7:0] data);
        int b0;
        b0 = n_byte;
        transfer(ser, four, sel, 1'b0, data);
        cmp("byte count", 8'h01, 8'(n_byte - b0));
        cmp("byte data", data, got_byte);
        cmp("byte sel", {7'h00, sel}, {7'h00, got_sel});
    endtask

    task automatic read_op(input logic ser, four, sel,
                           input logic [7:0] data);
        int r0;
        int d0;
        r0 = n_rsp;
        d0 = n_done;
        @(posedge clk_i);
        rd_data_i <= data;
        transfer(ser, four, sel, 1'b1, ~data);
        cmp("answer count", 8'h01, 8'(n_rsp - r0));
        cmp("answer data", data, got_rsp);
        cmp("read done count", 8'h01, 8'(n_done - d0));
    endtask

    task automatic set_width(input logic four);
        @(posedge clk_i);
        width_set_i <= 1'b1;
        width_four_i <= four;
        @(posedge clk_i);
        width_set_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        cmp("mode_four_o", {7'h00, four}, {7'h00, mode_four_o});
    endtask

    task automatic t_reset_default();
        @(negedge clk_i);
        cmp("mode_four_o", 8'h00, {7'h00, mode_four_o});
        write_op(1'b0, 1'b0, 1'b1, 8'hA5);
    endtask

    task automatic t_eight_bus();
        write_op(1'b0, 1'b0, 1'b0, 8'h00);
        write_op(1'b0, 1'b0, 1'b1, 8'hFF);
        read_op(1'b0, 1'b0, 1'b0, 8'h3C);
    endtask

    task automatic t_four_bus();
        set_width(1'b1);
        write_op(1'b0, 1'b1, 1'b1, 8'h5A);
        write_op(1'b0, 1'b1, 1'b0, 8'h81);
        read_op(1'b0, 1'b1, 1'b0, 8'hC3);
        read_op(1'b0, 1'b1, 1'b1, 8'h1E);
    endtask

    task automatic t_serial_link();
        write_op(1'b1, 1'b0, 1'b1, 8'h96);
        write_op(1'b1, 1'b0, 1'b0, 8'h01);
        read_op(1'b1, 1'b0, 1'b0, 8'h69);
        read_op(1'b1, 1'b0, 1'b1, 8'h80);
    endtask

    // Reset in mid-run, while still in 4-bit width, must fall back to 8-bit
    task automatic t_mid_reset();
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset_default();
    endtask

    task automatic t_back_to_eight();
        set_width(1'b0);
        write_op(1'b0, 1'b0, 1'b0, 8'h7E);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset_default();
        t_eight_bus();
        t_four_bus();
        t_serial_link();
        t_mid_reset();
        t_back_to_eight();
        summarize();
    end
endmodule
